// *** src/eqs_top.sv ***
/*
  Error/event queue with status housekeeping, reached over APB.
  Assumes APB master on core_clk; event sources on the same clock.
  Limitation: DEPTH must be a power of two for the pointers to wrap.
*/
// Functional notes
// - Codes are signed 16-bit values
// - Zero means nothing pending
// - Description length capped at 255
// - New entries appended, read oldest first
// - Overflow keeps oldest, last slot becomes -350
// - Exactly four entries of storage
// - Summary bit set while queue not empty
// - Full query returns oldest entry, removes it
// - Code query returns code only, removes it
// - Count query returns count, no change
// - Reset restores fixed device function defaults
// - Reset enters both idle states
// - Reset leaves enables and status untouched
// - Clear status empties events and queue
// - Preset touches only enables and filters
// - Device structures: enables ones, positive filters
// - Mandatory structures: enables zero, positive filters
// - Preset leaves request enables and settings alone
// - Questionable register is 16 bits wide
`timescale 1ns/1ns
`default_nettype none

module eqs_top #(
  parameter int DEPTH = eqs_pkg::QUEUE_DEPTH  // Queue entries
) (
  input  wire logic        core_clk,     // 125 MHz clock
  input  wire logic        reset,        // Synchronous, active high
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB enable
  input  wire logic        pwrite,       // APB direction
  input  wire logic [7:0]  paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error
  input  wire logic        evt_valid,    // Error detected this cycle
  input  wire eqs_pkg::eqs_entry_t evt_entry, // Detected error
  input  wire logic [15:0] ques_cond,    // Questionable condition bits
  input  wire logic        op_start,     // Operation begins (leaves idle)
  output logic             eq_summary,   // Queue not empty
  output logic [15:0]      dev_func      // Device function settings
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int PW = $clog2(DEPTH);                 // Pointer width

  eqs_pkg::eqs_entry_t  mem_r [DEPTH];               // Queue storage
  logic [PW-1:0]        rd_ptr_r;                    // Oldest slot
  logic [PW:0]          count_r;                     // Entries held
  eqs_pkg::eqs_stat_cfg_t oper_r, ques_r, devd_r;    // Status configs
  logic [15:0]          ques_evt_r;                  // Questionable events
  logic [15:0]          ques_prev_r;                 // Last condition
  logic [7:0]           sre_r, ese_r, esr_r;         // Standard regs
  logic                 ocis_r, oqis_r;              // Idle states
  logic [15:0]          dev_func_r;                  // Device settings

  logic                 acc, wr, rd;                 // Access strobes
  logic                 do_rst, do_cls, do_preset;   // Command strobes
  logic                 pop, push;                   // Queue moves
  logic                 full;                        // Queue full
  logic [PW-1:0]        wr_idx;                      // Push slot
  logic [PW-1:0]        last_idx;                    // Final slot
  eqs_pkg::eqs_entry_t  head;                        // Oldest entry
  eqs_pkg::eqs_entry_t  in_entry;                    // Capped entry
  logic [15:0]          ques_edge;                   // Filtered edges
  logic [31:0]          rdata_nxt;                   // Read mux
  logic                 setup;                       // APB setup cycle
  logic                 pop_ok_r;                    // Queue held entries at setup
  logic [31:0]          prdata_r;                    // Registered answer
  logic [31:0]          status_word;                 // Summary and idle flags
  localparam logic [7:0] OVF_LEN = 8'h0e;            // Length of overflow text

  // Address match helper, used by the write, command and pop decodes; the read mux uses a case
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  assign rd  = acc && !pwrite;
  assign setup = psel && !penable;
  assign do_rst    = wr && hit(paddr, eqs_pkg::OFF_CTRL) && pwdata[eqs_pkg::CTRL_RST_BIT];
  assign do_cls    = wr && hit(paddr, eqs_pkg::OFF_CTRL) && pwdata[eqs_pkg::CTRL_CLS_BIT];
  assign do_preset = wr && hit(paddr, eqs_pkg::OFF_CTRL) && pwdata[eqs_pkg::CTRL_PRESET_BIT];

  // Pops only happen on a non-empty queue; empty answers zero instead
  // The empty decision is the one frozen at setup, so answer and pop agree
  assign pop  = rd && (hit(paddr, eqs_pkg::OFF_POP_FULL) || hit(paddr, eqs_pkg::OFF_POP_CODE))
                && pop_ok_r;
  assign push = evt_valid || (wr && hit(paddr, eqs_pkg::OFF_PUSH));
  assign full = (count_r == (PW+1)'(DEPTH));
  assign head = mem_r[rd_ptr_r];
  assign wr_idx   = rd_ptr_r + PW'(count_r);
  assign last_idx = rd_ptr_r + PW'(DEPTH - 1);
  // Pointers wrap by truncation, so DEPTH must stay a power of two

  // Capped entry; hardware source wins over a bus push in the same cycle
  always_comb begin
    in_entry = evt_valid ? evt_entry
                         : eqs_pkg::eqs_entry_t'({pwdata[15:0], pwdata[23:16]});
    if (in_entry.len > eqs_pkg::DESC_MAX_LEN)
      in_entry.len = eqs_pkg::DESC_MAX_LEN;
  end

  // ****************************************************************
  // Queue storage and pointers
  // ****************************************************************
  // Push lands behind the last entry; on overflow the final slot is overwritten
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++)
        mem_r[i] <= '0;
    end else if (push && !do_cls) begin
      if (full && !pop) begin
        mem_r[last_idx].code <= eqs_pkg::CODE_OVERFLOW;
        mem_r[last_idx].len  <= OVF_LEN;
      end else begin
        mem_r[wr_idx] <= in_entry;
      end
    end
  end

  // Read pointer moves on pop; clear status empties the queue
  always_ff @(posedge core_clk) begin
    if (reset || do_cls) begin
      rd_ptr_r <= '0;
    end else if (pop) begin
      rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  // Count: overflow holds it at the full value
  // A pop and a push in one cycle leave it unchanged, full or not
  always_ff @(posedge core_clk) begin
    if (reset || do_cls) begin
      count_r <= '0;
    end else if (pop && !push) begin
      count_r <= count_r - 1'b1;
    end else if (push && !pop && !full) begin
      count_r <= count_r + 1'b1;
    end
  end

  assign eq_summary = (count_r != '0);

  // ****************************************************************
  // Status structures
  // ****************************************************************
  // Enables and filters: preset and bus writes; device reset leaves them alone
  always_ff @(posedge core_clk) begin
    if (reset) begin
      oper_r <= '{eqs_pkg::STAT_ALL_ZEROS, eqs_pkg::STAT_ALL_ONES, eqs_pkg::STAT_ALL_ZEROS};
      ques_r <= '{eqs_pkg::STAT_ALL_ZEROS, eqs_pkg::STAT_ALL_ONES, eqs_pkg::STAT_ALL_ZEROS};
      devd_r <= '{eqs_pkg::STAT_ALL_ONES, eqs_pkg::STAT_ALL_ONES, eqs_pkg::STAT_ALL_ZEROS};
    end else if (do_preset) begin
      oper_r <= '{eqs_pkg::STAT_ALL_ZEROS, eqs_pkg::STAT_ALL_ONES, eqs_pkg::STAT_ALL_ZEROS};
      ques_r <= '{eqs_pkg::STAT_ALL_ZEROS, eqs_pkg::STAT_ALL_ONES, eqs_pkg::STAT_ALL_ZEROS};
      devd_r <= '{eqs_pkg::STAT_ALL_ONES, eqs_pkg::STAT_ALL_ONES, eqs_pkg::STAT_ALL_ZEROS};
    end else if (wr) begin
      if (hit(paddr, eqs_pkg::OFF_OPER_EN))  oper_r.en  <= pwdata[15:0];
      if (hit(paddr, eqs_pkg::OFF_OPER_PTR)) oper_r.ptr <= pwdata[15:0];
      if (hit(paddr, eqs_pkg::OFF_OPER_NTR)) oper_r.ntr <= pwdata[15:0];
      if (hit(paddr, eqs_pkg::OFF_QUES_EN))  ques_r.en  <= pwdata[15:0];
      if (hit(paddr, eqs_pkg::OFF_QUES_PTR)) ques_r.ptr <= pwdata[15:0];
      if (hit(paddr, eqs_pkg::OFF_QUES_NTR)) ques_r.ntr <= pwdata[15:0];
      if (hit(paddr, eqs_pkg::OFF_DEV_EN))   devd_r.en  <= pwdata[15:0];
      if (hit(paddr, eqs_pkg::OFF_DEV_PTR))  devd_r.ptr <= pwdata[15:0];
      if (hit(paddr, eqs_pkg::OFF_DEV_NTR))  devd_r.ntr <= pwdata[15:0];
    end
  end

  // Request enables untouched by preset and by device reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sre_r <= 8'h00;
      ese_r <= 8'h00;
    end else if (wr) begin
      if (hit(paddr, eqs_pkg::OFF_SRE)) sre_r <= pwdata[7:0];
      if (hit(paddr, eqs_pkg::OFF_ESE)) ese_r <= pwdata[7:0];
    end
  end

  // Questionable events: 16-bit, filtered edges; set wins over clear
  assign ques_edge = (ques_cond & ~ques_prev_r & ques_r.ptr)
                   | (~ques_cond & ques_prev_r & ques_r.ntr);
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ques_evt_r  <= '0;
      ques_prev_r <= '0;
    end else begin
      ques_prev_r <= ques_cond;
      ques_evt_r  <= (do_cls ? 16'h0000 : ques_evt_r) | ques_edge;
    end
  end

  // Standard event register: software write sets, clear status clears
  // Bits only accumulate; one write cannot both set and clear them
  always_ff @(posedge core_clk) begin
    if (reset || do_cls) begin
      esr_r <= 8'h00;
    end else if (wr && hit(paddr, eqs_pkg::OFF_ESR)) begin
      esr_r <= esr_r | pwdata[7:0];
    end
  end

  // ****************************************************************
  // Device reset effects
  // ****************************************************************
  // Reset wins over a new operation start in the same cycle
  // Idle flags drop when an operation starts and return on device reset
  always_ff @(posedge core_clk) begin
    if (reset || do_rst) begin
      ocis_r <= 1'b1;
      oqis_r <= 1'b1;
    end else if (op_start) begin
      ocis_r <= 1'b0;
      oqis_r <= 1'b0;
    end
  end

  // Device functions return to defaults independent of history
  always_ff @(posedge core_clk) begin
    if (reset || do_rst) begin
      dev_func_r <= eqs_pkg::DEV_FUNC_RESET;
    end else if (wr && hit(paddr, eqs_pkg::OFF_DEV_FUNC)) begin
      dev_func_r <= pwdata[15:0];
    end
  end
  assign dev_func = dev_func_r;

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Status word built from the named bit positions
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[eqs_pkg::STAT_EQ_BIT]   = eq_summary;
    status_word[eqs_pkg::STAT_OCIS_BIT] = ocis_r;
    status_word[eqs_pkg::STAT_OQIS_BIT] = oqis_r;
  end

  // Combinational mux; empty queue answers code zero (no error)
  always_comb begin
    rdata_nxt = eqs_pkg::APB_UNMAPPED;
    case (paddr)
      eqs_pkg::OFF_POP_FULL: rdata_nxt = eq_summary ? {8'h00, head.len, head.code} : 32'h0000_0000;
      eqs_pkg::OFF_POP_CODE: rdata_nxt = eq_summary ? {{16{head.code[15]}}, head.code}
                                                    : {16'h0, eqs_pkg::CODE_NO_ERROR};
      eqs_pkg::OFF_COUNT:    rdata_nxt = {{(31-PW){1'b0}}, count_r};
      eqs_pkg::OFF_STATUS:   rdata_nxt = status_word;
      eqs_pkg::OFF_OPER_EN:  rdata_nxt = {16'h0, oper_r.en};
      eqs_pkg::OFF_OPER_PTR: rdata_nxt = {16'h0, oper_r.ptr};
      eqs_pkg::OFF_OPER_NTR: rdata_nxt = {16'h0, oper_r.ntr};
      eqs_pkg::OFF_QUES_EN:  rdata_nxt = {16'h0, ques_r.en};
      eqs_pkg::OFF_QUES_PTR: rdata_nxt = {16'h0, ques_r.ptr};
      eqs_pkg::OFF_QUES_NTR: rdata_nxt = {16'h0, ques_r.ntr};
      eqs_pkg::OFF_DEV_EN:   rdata_nxt = {16'h0, devd_r.en};
      eqs_pkg::OFF_DEV_PTR:  rdata_nxt = {16'h0, devd_r.ptr};
      eqs_pkg::OFF_DEV_NTR:  rdata_nxt = {16'h0, devd_r.ntr};
      eqs_pkg::OFF_SRE:      rdata_nxt = {24'h0, sre_r};
      eqs_pkg::OFF_ESE:      rdata_nxt = {24'h0, ese_r};
      eqs_pkg::OFF_ESR:      rdata_nxt = {24'h0, esr_r};
      eqs_pkg::OFF_QUES_EVT: rdata_nxt = {16'h0, ques_evt_r};
      eqs_pkg::OFF_DEV_FUNC: rdata_nxt = {16'h0, dev_func_r};
      default:               rdata_nxt = eqs_pkg::APB_UNMAPPED;
    endcase
  end
  // ****************************************************************
  // Read data register
  // ****************************************************************
  // The answer is chosen in the setup cycle and held in a flop, so the
  // access cycle still completes with zero wait states. The empty flag is
  // frozen with it: an event landing between setup and access is kept
  // for the next query instead of being popped unseen.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata_r <= eqs_pkg::APB_UNMAPPED;
      pop_ok_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= rdata_nxt;
      pop_ok_r <= eq_summary;
    end
  end
  assign prdata = prdata_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_SUMMARY: assert property (@(posedge core_clk) disable iff (reset)
    eq_summary == (count_r != '0)) else $error("summary mismatch");

  AST_DEPTH: assert property (@(posedge core_clk) disable iff (reset)
    count_r <= (PW+1)'(DEPTH)) else $error("count above depth");

  AST_OVF: assert property (@(posedge core_clk) disable iff (reset)
    (full && push && !pop && !do_cls) |=> (mem_r[$past(last_idx)].code == eqs_pkg::CODE_OVERFLOW && full))
    else $error("overflow not marked");

  AST_POP: assert property (@(posedge core_clk) disable iff (reset)
    (pop && !push && !do_cls) |=> count_r == $past(count_r) - 1'b1) else $error("pop count");

  AST_COUNT_RO: assert property (@(posedge core_clk) disable iff (reset)
    (rd && hit(paddr, eqs_pkg::OFF_COUNT) && !push) |=> $stable(count_r)) else $error("count read altered");

  AST_EMPTY: assert property (@(posedge core_clk) disable iff (reset)
    (rd && hit(paddr, eqs_pkg::OFF_POP_CODE) && !eq_summary) |-> prdata == 32'h0)
    else $error("empty code not zero");

  AST_CLS: assert property (@(posedge core_clk) disable iff (reset)
    do_cls |=> (count_r == '0 && esr_r == 8'h00)) else $error("clear status");

  // Preset may share its write with clear status, which then empties the events
  AST_PRESET: assert property (@(posedge core_clk) disable iff (reset)
    do_preset |=> (devd_r.en == 16'hffff && ques_r.en == 16'h0 && oper_r.ptr == 16'hffff
                   && ($stable(esr_r) || $past(do_cls)) && $stable(sre_r))) else $error("preset values");

  // A combined reset and preset write legitimately rewrites the filters
  AST_RST: assert property (@(posedge core_clk) disable iff (reset)
    do_rst |=> (ocis_r && oqis_r && dev_func_r == eqs_pkg::DEV_FUNC_RESET && ($stable(ques_r) || $past(do_preset))))
    else $error("device reset");

  // A pop only ever happens with an entry to take
  AST_POP_SAFE: assert property (@(posedge core_clk) disable iff (reset)
    pop |-> (count_r != '0)) else $error("pop from empty queue");

  // An empty full-entry query answers the no-error code
  AST_EMPTY_FULL: assert property (@(posedge core_clk) disable iff (reset)
    (rd && hit(paddr, eqs_pkg::OFF_POP_FULL) && !pop_ok_r) |-> prdata == 32'h0)
    else $error("empty entry not zero");

  // A push below full grows the queue by one
  AST_PUSH_GROW: assert property (@(posedge core_clk) disable iff (reset)
    (push && !pop && !full && !do_cls) |=> count_r == $past(count_r) + 1'b1) else $error("push count");

  // The first entry into an empty queue becomes the head
  AST_FIFO_HEAD: assert property (@(posedge core_clk) disable iff (reset)
    (push && !do_cls && count_r == '0) |=> head == $past(in_entry)) else $error("head not first");

  // A filtered edge is never lost, even beside clear status
  AST_QUES_SET: assert property (@(posedge core_clk) disable iff (reset)
    (ques_edge != 16'h0) |=> ((ques_evt_r & $past(ques_edge)) == $past(ques_edge)))
    else $error("event lost");

  // Mandatory structures get zero enables and rising-edge filters
  AST_PRESET_MAND: assert property (@(posedge core_clk) disable iff (reset)
    do_preset |=> (oper_r.en == 16'h0 && oper_r.ntr == 16'h0 && ques_r.ptr == 16'hffff && ques_r.ntr == 16'h0))
    else $error("preset mandatory values");

  // Preset leaves the queue alone
  AST_PRESET_KEEP: assert property (@(posedge core_clk) disable iff (reset)
    (do_preset && !push) |=> $stable(count_r)) else $error("preset moved queue");

  // Device reset leaves enables and status configuration untouched
  AST_RST_KEEP: assert property (@(posedge core_clk) disable iff (reset)
    (do_rst && !do_preset) |=> ($stable(oper_r) && $stable(ese_r) && $stable(sre_r)))
    else $error("device reset changed enables");

endmodule // eqs_top
`default_nettype wire

// *** src/eqs_pkg.sv ***
/*
  Package for the error queue and status preset block: register offsets,
  field layouts, reset and preset values, queue constants and carriers.
  Assumes a 32-bit APB slave with word-aligned registers.
*/
`default_nettype none

package eqs_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL      = 8'h00;  // Command strobes (write)
  localparam logic [7:0] OFF_PUSH      = 8'h04;  // Code[15:0], desc length[23:16]
  localparam logic [7:0] OFF_POP_FULL  = 8'h08;  // Full-entry query (read pops)
  localparam logic [7:0] OFF_POP_CODE  = 8'h0c;  // Code-only query (read pops)
  localparam logic [7:0] OFF_COUNT     = 8'h10;  // Entry count
  localparam logic [7:0] OFF_STATUS    = 8'h14;  // Summary and idle flags
  localparam logic [7:0] OFF_OPER_EN   = 8'h18;  // Operation enable
  localparam logic [7:0] OFF_OPER_PTR  = 8'h1c;  // Operation positive filter
  localparam logic [7:0] OFF_OPER_NTR  = 8'h20;  // Operation negative filter
  localparam logic [7:0] OFF_QUES_EN   = 8'h24;  // Questionable enable
  localparam logic [7:0] OFF_QUES_PTR  = 8'h28;  // Questionable positive filter
  localparam logic [7:0] OFF_QUES_NTR  = 8'h2c;  // Questionable negative filter
  localparam logic [7:0] OFF_DEV_EN    = 8'h30;  // Device-dependent enable
  localparam logic [7:0] OFF_DEV_PTR   = 8'h34;  // Device-dependent positive filter
  localparam logic [7:0] OFF_DEV_NTR   = 8'h38;  // Device-dependent negative filter
  localparam logic [7:0] OFF_SRE       = 8'h3c;  // Service-request enable
  localparam logic [7:0] OFF_ESE       = 8'h40;  // Standard event enable
  localparam logic [7:0] OFF_ESR       = 8'h44;  // Standard event register
  localparam logic [7:0] OFF_QUES_EVT  = 8'h48;  // Questionable event
  localparam logic [7:0] OFF_DEV_FUNC  = 8'h4c;  // Device function settings

  // ****************************************************************
  // Control register bit positions
  // ****************************************************************
  localparam int CTRL_RST_BIT    = 0;  // Device reset
  localparam int CTRL_CLS_BIT    = 1;  // Clear status
  localparam int CTRL_PRESET_BIT = 2;  // Status preset

  // Status register bit positions
  localparam int STAT_EQ_BIT     = 2;  // Error queue not empty
  localparam int STAT_OCIS_BIT   = 8;  // Operation-complete idle
  localparam int STAT_OQIS_BIT   = 9;  // Operation-query idle

  // ****************************************************************
  // Queue constants
  // ****************************************************************
  localparam int                QUEUE_DEPTH   = 4;        // Entries held
  localparam logic signed [15:0] CODE_NO_ERROR = 16'sh0000; // Nothing pending
  localparam logic signed [15:0] CODE_OVERFLOW = -16'sd350; // Queue overflow
  localparam logic [7:0]        DESC_MAX_LEN  = 8'hff;     // 255 characters

  // ****************************************************************
  // Reset and preset values
  // ****************************************************************
  localparam logic [15:0] STAT_ALL_ONES   = 16'hffff; // Every bit set
  localparam logic [15:0] STAT_ALL_ZEROS  = 16'h0000; // Every bit clear
  localparam logic [15:0] DEV_FUNC_RESET  = 16'h0000; // Default settings
  localparam logic [31:0] APB_UNMAPPED    = 32'h0000_0000; // Unmapped read

  // One queue entry: code plus description length
  typedef struct packed {
    logic signed [15:0] code;  // Error or event number
    logic [7:0]         len;   // Description plus device text length
  } eqs_entry_t;

  // One status structure's configuration
  typedef struct packed {
    logic [15:0] en;   // Enable mask
    logic [15:0] ptr;  // Positive transition filter
    logic [15:0] ntr;  // Negative transition filter
  } eqs_stat_cfg_t;

endpackage
`default_nettype wire

// *** verification/eqs_host_model.sv ***
/*
  Host controller model: issues register queries and commands over APB.
  Assumes eqs_top answers on the same core_clk; the bench calls xfer.
*/
`timescale 1ns/1ns
`default_nettype none

module eqs_host_model (
  input  wire logic        core_clk, // Bus clock
  input  wire logic [31:0] prdata,   // Read data from the block
  input  wire logic        pready,   // Ready from the block
  output logic             psel,     // Select
  output logic             penable,  // Access phase
  output logic             pwrite,   // Direction
  output logic [7:0]       paddr,    // Byte address
  output logic [31:0]      pwdata    // Write data
);
  // ****************************************************************
  // Bus idle at time zero
  // ****************************************************************
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // One transfer; address and data lines are left inverted so stale data never looks valid
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule // eqs_host_model
`default_nettype wire

// *** verification/tb_top.sv ***
/*
  Self-checking bench for eqs_top: queue, overflow, preset, reset, clear.
  Assumes eqs_host_model for the bus and the package constants.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic core_clk = 1'b0, reset = 1'b1, evt_valid = 1'b0, op_start = 1'b0; // Clock, reset, strobes
  logic [15:0] ques_cond = 16'h0000;                 // Questionable inputs
  eqs_pkg::eqs_entry_t evt_entry = '0;              // Event carrier
  logic psel, penable, pwrite, pready, pslverr;     // APB controls
  logic [7:0]  paddr;                               // APB address
  logic [31:0] pwdata, prdata, q;                   // APB data
  logic        eq_summary;                          // Queue not empty
  logic [15:0] dev_func;                            // Device settings
  int errors = 0, n_compared = 0;                   // Tally
  logic [7:0]  offs [9];                            // Preset table offsets
  logic [31:0] exps [9];                            // Preset table values

  always #4 core_clk = ~core_clk; // 125 MHz

  eqs_host_model u_host (.core_clk(core_clk), .prdata(prdata), .pready(pready), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  eqs_top u_dut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evt_valid(evt_valid), .evt_entry(evt_entry), .ques_cond(ques_cond), .op_start(op_start),
    .eq_summary(eq_summary), .dev_func(dev_func));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    u_host.xfer(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask
  task automatic pulse_evt(input logic [15:0] c, input logic [7:0] l); // Source-side detection
    @(posedge core_clk);
    evt_valid <= 1'b1;
    evt_entry <= {c, l};
    @(posedge core_clk);
    evt_valid <= 1'b0;
    evt_entry <= ~{c, l};
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Watchdog, far beyond the roughly 150 cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    tally_and_finish;
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rchk(eqs_pkg::OFF_COUNT, 32'h0);
    rchk(eqs_pkg::OFF_STATUS, 32'h300);
    rchk(8'h80, 32'h0);
    check({31'h0, pslverr}, 32'h0);
    $display("test reset done");
    wr(eqs_pkg::OFF_PUSH, 32'h0005_ff9a);
    wr(eqs_pkg::OFF_PUSH, 32'h00ff_7fff);
    wr(eqs_pkg::OFF_PUSH, 32'h0000_8000);
    wr(eqs_pkg::OFF_PUSH, 32'h0001_0001);
    pulse_evt(16'h0002, 8'h03); // Fifth entry overflows
    rchk(eqs_pkg::OFF_COUNT, 32'h4);
    rchk(eqs_pkg::OFF_STATUS, 32'h304);
    rchk(eqs_pkg::OFF_POP_FULL, 32'h0005_ff9a);
    rchk(eqs_pkg::OFF_POP_FULL, 32'h00ff_7fff);
    rchk(eqs_pkg::OFF_POP_CODE, 32'hffff_8000);
    rchk(eqs_pkg::OFF_POP_FULL, {8'h00, 8'd14, eqs_pkg::CODE_OVERFLOW});
    rchk(eqs_pkg::OFF_POP_FULL, 32'h0);
    rchk(eqs_pkg::OFF_POP_CODE, 32'h0);
    check({31'h0, eq_summary}, 32'h0);
    pulse_evt(16'h0007, 8'h02);
    rchk(eqs_pkg::OFF_POP_CODE, 32'h7);
    $display("test queue done");
    wr(eqs_pkg::OFF_OPER_EN, 32'h1234);
    wr(eqs_pkg::OFF_QUES_NTR, 32'h5);
    wr(eqs_pkg::OFF_DEV_EN, 32'h0);
    wr(eqs_pkg::OFF_DEV_NTR, 32'h3);
    wr(eqs_pkg::OFF_SRE, 32'ha5);
    wr(eqs_pkg::OFF_PUSH, 32'h0001_0010);
    ques_cond <= 16'h0001;
    wr(eqs_pkg::OFF_CTRL, 32'h4);
    offs = '{eqs_pkg::OFF_OPER_EN, eqs_pkg::OFF_OPER_PTR, eqs_pkg::OFF_OPER_NTR, eqs_pkg::OFF_QUES_EN,
      eqs_pkg::OFF_QUES_NTR, eqs_pkg::OFF_DEV_EN, eqs_pkg::OFF_DEV_PTR, eqs_pkg::OFF_DEV_NTR, eqs_pkg::OFF_SRE};
    exps = '{32'h0, 32'hffff, 32'h0, 32'h0, 32'h0, 32'hffff, 32'hffff, 32'h0, 32'ha5};
    foreach (offs[i]) rchk(offs[i], exps[i]);
    rchk(eqs_pkg::OFF_COUNT, 32'h1);
    rchk(eqs_pkg::OFF_QUES_EVT, 32'h1);
    $display("test preset done");
    @(posedge core_clk);
    op_start <= 1'b1;
    @(posedge core_clk);
    op_start <= 1'b0;
    rchk(eqs_pkg::OFF_STATUS, 32'h004);
    wr(eqs_pkg::OFF_DEV_FUNC, 32'h55);
    wr(eqs_pkg::OFF_OPER_EN, 32'h77);
    wr(eqs_pkg::OFF_CTRL, 32'h1);
    @(negedge core_clk);
    check({16'h0, dev_func}, {16'h0, eqs_pkg::DEV_FUNC_RESET});
    rchk(eqs_pkg::OFF_STATUS, 32'h304);
    rchk(eqs_pkg::OFF_OPER_EN, 32'h77);
    rchk(eqs_pkg::OFF_QUES_EVT, 32'h1);
    $display("test device reset done");
    wr(eqs_pkg::OFF_ESR, 32'h21);
    wr(eqs_pkg::OFF_CTRL, 32'h2);
    rchk(eqs_pkg::OFF_COUNT, 32'h0);
    rchk(eqs_pkg::OFF_ESR, 32'h0);
    rchk(eqs_pkg::OFF_QUES_EVT, 32'h0);
    ques_cond <= 16'h8001;
    rchk(eqs_pkg::OFF_QUES_EVT, 32'h8000);
    $display("test clear status done");
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
